/* File: hdl/ster_core.sv */
// Error recovery sequencer for a disk controller acting as bus target.
// Assumes a bus phase engine on the same clock that reports events as
// one-cycle pulses and carries out the orders given on ACT_O.

// What this block does
// - Message Out parity: handshake until ATN drops, then re-request, two retries max.
// - Failed Message Out/Command recovery: check condition if LUN known, else bus free.
// - Command parity: Message In with Restore Pointers, collect CDB again, two retries.
// - Data Out parity: restore and receive again twice, then check condition parity.
// - Initiator Detected Error: restore and repeat prior phase; repeat or impossible ends.
// - Failed Status phase retry after Initiator Detected Error goes bus free, no sense.
// - Rejected Command Complete releases the bus at once, not an error.
// - Rejected Disconnect keeps the bus; later disconnect only with granted privilege.
// - Rejected reselection Identify: bus free, abort, record message reject sense.
// - Rejected Linked Command Complete: bus free, break link, message reject sense.
// - Rejected own Message Reject ends command with check condition, reject sense.
// - Rejected Restore Pointers drops recovery, check condition with original error.
// - Rejected Save Data Pointer keeps connection and carries on.
// - Rejected synchronous request switches to asynchronous transfers.
// - Message Parity Error resends message; second one: bus free, abort, parity sense.
// - Reselection timer from SEL and I/O; abort attempt after 250 ms.
// - Two more reselection tries, then end command with select failed sense.
// - Internal error: check with hardware sense if LUN known, else bus free.
// - Handshake timeout: bus free, abort, record internal controller error sense.
// - Abrupt bus free discards all command state; initiator requests sense.
module ster_core #(
  parameter logic [ster_pkg::RESEL_TMO_W-1:0] RESEL_TMO_CYC =
    ster_pkg::RESEL_TMO_W'(ster_pkg::RESEL_TMO_CYC)
) (
  // Clock and reset
  input  wire logic                 MCLK_I,
  input  wire logic                 SYS_RST_I,
  // Bus pin
  input  wire logic                 ATN_I,
  // Phase engine events and context
  input  wire ster_pkg::ster_evt_s  EVT_I,
  input  wire ster_pkg::ster_rej_e  REJ_KIND_I,
  input  wire ster_pkg::ster_ctx_s  CTX_I,
  // Orders and status
  output ster_pkg::ster_act_s       ACT_O,
  output ster_pkg::ster_sense_e     SENSE_O,
  output logic                      ASYNC_O,
  output logic                      DISC_OK_O,
  output logic                      RECOVER_O,
  output logic                      RESEL_BUSY_O
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MO_DRAIN,
    ST_RETRY,
    ST_RESEL
  } ster_state_e;

  ster_state_e                  state_r, state_nxt;
  ster_pkg::ster_kind_e         kind_r, kind_nxt;
  logic [1:0]                   cnt_r, cnt_nxt;
  logic [ster_pkg::RESEL_TMO_W-1:0] tmr_r, tmr_nxt;
  ster_pkg::ster_act_s          act_r, act_nxt;
  ster_pkg::ster_sense_e        sense_r, sense_nxt;
  logic                         async_r, async_nxt;
  logic                         disc_ok_r, disc_ok_nxt;
  logic [2:0]                   atn_sync_r;
  logic                         atn_r;

  // ATN pin: three stages, level accepted when the last two agree
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      atn_sync_r <= ster_pkg::ATN_SYNC_RST;
      atn_r      <= 1'b0;
    end else begin
      atn_sync_r <= {atn_sync_r[1:0], ATN_I};
      if (atn_sync_r[1] == atn_sync_r[2]) begin
        atn_r <= atn_sync_r[2];
      end
    end
  end

  // Decoding of the recovery in progress
  wire logic is_mo    = (kind_r == ster_pkg::KIND_MSG_OUT);
  wire logic is_cmd   = (kind_r == ster_pkg::KIND_CMD);
  wire logic is_do    = (kind_r == ster_pkg::KIND_DATA_OUT);
  wire logic is_ide   = (kind_r == ster_pkg::KIND_IDE);
  wire logic is_mpe   = (kind_r == ster_pkg::KIND_MPE);
  wire logic [1:0] retry_lim = (is_ide || is_mpe) ? ster_pkg::MSG_RETRY_MAX
                                                  : ster_pkg::PAR_RETRY_MAX;
  // cnt_r holds the retries already ordered; a repeat at the limit gives up
  wire logic at_limit = (cnt_r >= retry_lim);
  wire logic repeat_err = (is_mo && EVT_I.mo_par) || (is_cmd && EVT_I.cmd_par) ||
                          (is_do && EVT_I.do_par) || (is_ide && EVT_I.ide_msg) ||
                          (is_mpe && EVT_I.mpe_msg);
  wire logic ide_stuck  = is_ide && EVT_I.no_retry;
  wire logic fail_now   = (repeat_err && at_limit) || ide_stuck;

  // Outcome of a failed recovery
  wire logic fail_free = ((is_mo || is_cmd) && !CTX_I.lun_known)
                      || (is_ide && CTX_I.retry_status)
                      || is_mpe;
  wire logic fail_abort = is_mpe;
  wire ster_pkg::ster_sense_e orig_sense =
    is_ide ? ster_pkg::SNS_ABORT_IDE : ster_pkg::SNS_ABORT_PARITY;
  wire ster_pkg::ster_sense_e fail_sense =
    ((is_mo || is_cmd) && !CTX_I.lun_known) ? ster_pkg::SNS_NONE :
    (is_ide && CTX_I.retry_status)          ? ster_pkg::SNS_NONE : orig_sense;

  // Timer end for the current reselection attempt
  wire logic resel_tmo = (state_r == ST_RESEL) && (tmr_r == RESEL_TMO_CYC);
  wire logic rej_any   = EVT_I.rej_msg;
  wire logic recovering = (kind_r != ster_pkg::KIND_NONE);

  always_comb begin
    state_nxt   = state_r;
    kind_nxt    = kind_r;
    cnt_nxt     = cnt_r;
    tmr_nxt     = tmr_r;
    sense_nxt   = sense_r;
    async_nxt   = async_r;
    disc_ok_nxt = disc_ok_r;
    act_nxt     = '0;

    // Abrupt bus free: nothing of the command is kept
    if (EVT_I.hs_tmo) begin
      act_nxt.bus_free  = 1'b1;
      act_nxt.abort_cmd = 1'b1;
      act_nxt.sense_set = 1'b1;
      sense_nxt         = ster_pkg::SNS_ABORT_INT_CTL;
      state_nxt         = ST_IDLE;
      kind_nxt          = ster_pkg::KIND_NONE;
    end else if (EVT_I.int_err) begin
      if (CTX_I.lun_known) begin
        act_nxt.check_cond = 1'b1;
        act_nxt.sense_set  = 1'b1;
        sense_nxt          = ster_pkg::SNS_HW_INT_CTL;
      end else begin
        act_nxt.bus_free  = 1'b1;
        act_nxt.abort_cmd = 1'b1;
      end
      state_nxt = ST_IDLE;
      kind_nxt  = ster_pkg::KIND_NONE;
    end else if (rej_any) begin
      case (REJ_KIND_I)
        ster_pkg::REJ_CMD_CPLT: begin
          act_nxt.bus_free = 1'b1;
          state_nxt        = ST_IDLE;
          kind_nxt         = ster_pkg::KIND_NONE;
        end
        ster_pkg::REJ_DISCONNECT: begin
          act_nxt.keep_conn = 1'b1;
          disc_ok_nxt       = CTX_I.disc_priv;
        end
        ster_pkg::REJ_IDENTIFY, ster_pkg::REJ_LINKED_CPLT: begin
          act_nxt.bus_free   = 1'b1;
          act_nxt.abort_cmd  = 1'b1;
          act_nxt.link_break = (REJ_KIND_I == ster_pkg::REJ_LINKED_CPLT);
          act_nxt.sense_set  = 1'b1;
          sense_nxt          = ster_pkg::SNS_ABORT_MSG_REJ;
          state_nxt          = ST_IDLE;
          kind_nxt           = ster_pkg::KIND_NONE;
        end
        ster_pkg::REJ_MSG_REJECT: begin
          act_nxt.check_cond = 1'b1;
          act_nxt.sense_set  = 1'b1;
          sense_nxt          = ster_pkg::SNS_ABORT_MSG_REJ;
          state_nxt          = ST_IDLE;
          kind_nxt           = ster_pkg::KIND_NONE;
        end
        ster_pkg::REJ_RESTORE_PTR: begin
          if (recovering) begin
            act_nxt.check_cond = 1'b1;
            act_nxt.sense_set  = 1'b1;
            sense_nxt          = orig_sense;
            state_nxt          = ST_IDLE;
            kind_nxt           = ster_pkg::KIND_NONE;
          end
        end
        ster_pkg::REJ_SAVE_PTR: begin
          act_nxt.keep_conn = 1'b1;
        end
        ster_pkg::REJ_SYNC_REQ: begin
          async_nxt = 1'b1;
        end
        default: begin
          act_nxt.keep_conn = 1'b0;
        end
      endcase
    end else begin
      case (state_r)
        ST_IDLE: begin
          // Entry orders count as the first retry; Message Out counts at resend
          cnt_nxt = ster_pkg::CNT_RST;
          if (EVT_I.mo_par) begin
            kind_nxt  = ster_pkg::KIND_MSG_OUT;
            act_nxt.hold_hs = 1'b1;
            state_nxt = ST_MO_DRAIN;
          end else if (EVT_I.cmd_par || EVT_I.do_par) begin
            kind_nxt = EVT_I.cmd_par ? ster_pkg::KIND_CMD : ster_pkg::KIND_DATA_OUT;
            act_nxt.msgin_restore = 1'b1;
            cnt_nxt   = 2'h1;
            state_nxt = ST_RETRY;
          end else if (EVT_I.ide_msg) begin
            kind_nxt = ster_pkg::KIND_IDE;
            if (EVT_I.no_retry) begin
              act_nxt.check_cond = !CTX_I.retry_status;
              act_nxt.bus_free   = CTX_I.retry_status;
              act_nxt.abort_cmd  = CTX_I.retry_status;
              act_nxt.sense_set  = !CTX_I.retry_status;
              sense_nxt = CTX_I.retry_status ? sense_r : ster_pkg::SNS_ABORT_IDE;
              kind_nxt  = ster_pkg::KIND_NONE;
            end else begin
              act_nxt.msgin_restore = 1'b1;
              cnt_nxt   = 2'h1;
              state_nxt = ST_RETRY;
            end
          end else if (EVT_I.mpe_msg) begin
            kind_nxt           = ster_pkg::KIND_MPE;
            act_nxt.resend_msg = 1'b1;
            cnt_nxt            = 2'h1;
            state_nxt          = ST_RETRY;
          end else if (EVT_I.resel_go) begin
            tmr_nxt   = '0;
            state_nxt = ST_RESEL;
          end
        end
        // ATN comes through the synchroniser: the drain ends 4 to 5 cycles late
        ST_MO_DRAIN: begin
          act_nxt.hold_hs = 1'b1;
          if (!atn_r) begin
            act_nxt.hold_hs    = 1'b0;
            act_nxt.req_resend = 1'b1;
            cnt_nxt   = cnt_r + 2'h1;
            state_nxt = ST_RETRY;
          end
        end
        ST_RETRY: begin
          if (fail_now) begin
            act_nxt.check_cond = !fail_free;
            act_nxt.bus_free   = fail_free;
            act_nxt.abort_cmd  = fail_abort || fail_free;
            act_nxt.sense_set  = (fail_sense != ster_pkg::SNS_NONE);
            if (fail_sense != ster_pkg::SNS_NONE) begin
              sense_nxt = fail_sense;
            end
            state_nxt = ST_IDLE;
            kind_nxt  = ster_pkg::KIND_NONE;
          end else if (repeat_err) begin
            if (is_mo) begin
              act_nxt.hold_hs = 1'b1;
              state_nxt = ST_MO_DRAIN;
            end else if (is_mpe) begin
              act_nxt.resend_msg = 1'b1;
              cnt_nxt = cnt_r + 2'h1;
            end else begin
              act_nxt.msgin_restore = 1'b1;
              cnt_nxt = cnt_r + 2'h1;
            end
          end else if (EVT_I.phase_ok) begin
            state_nxt = ST_IDLE;
            kind_nxt  = ster_pkg::KIND_NONE;
          end
        end
        ST_RESEL: begin
          tmr_nxt = tmr_r + 1'b1;
          if (EVT_I.resel_ack) begin
            state_nxt = ST_IDLE;
          end else if (resel_tmo) begin
            act_nxt.resel_abort = 1'b1;
            tmr_nxt = '0;
            if (cnt_r < ster_pkg::RESEL_RETRY_MAX) begin
              act_nxt.resel_retry = 1'b1;
              cnt_nxt = cnt_r + 2'h1;
            end else begin
              act_nxt.abort_cmd = 1'b1;
              act_nxt.sense_set = 1'b1;
              sense_nxt = ster_pkg::SNS_ABORT_SEL_FAIL;
              state_nxt = ST_IDLE;
            end
          end
        end
        default: begin
          state_nxt = ST_IDLE;
          kind_nxt  = ster_pkg::KIND_NONE;
        end
      endcase
    end
  end

  // Sequencer state and orders
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      state_r <= ST_IDLE;
      kind_r  <= ster_pkg::KIND_NONE;
      act_r   <= '0;
    end else begin
      state_r <= state_nxt;
      kind_r  <= kind_nxt;
      act_r   <= act_nxt;
    end
  end

  // Retry and reselection counters
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      cnt_r <= ster_pkg::CNT_RST;
      tmr_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  // Levels that outlast one recovery; disconnect allowed until refused
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      sense_r   <= ster_pkg::SNS_NONE;
      async_r   <= 1'b0;
      disc_ok_r <= 1'b1;
    end else begin
      sense_r   <= sense_nxt;
      async_r   <= async_nxt;
      disc_ok_r <= disc_ok_nxt;
    end
  end

  // Status flags registered alongside the state
  logic recover_r;
  logic resel_busy_r;
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      recover_r    <= 1'b0;
      resel_busy_r <= 1'b0;
    end else begin
      recover_r    <= (kind_nxt != ster_pkg::KIND_NONE);
      resel_busy_r <= (state_nxt == ST_RESEL);
    end
  end

  assign ACT_O        = act_r;
  assign SENSE_O      = sense_r;
  assign ASYNC_O      = async_r;
  assign DISC_OK_O    = disc_ok_r;
  assign RECOVER_O    = recover_r;
  assign RESEL_BUSY_O = resel_busy_r;

endmodule : ster_core

/* File: common/ster_pkg.sv */
// Constants and carrier types for the target-side bus error recovery sequencer.
// Assumes a single 100 MHz controller clock shared with the bus phase engine.
package ster_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned RESEL_TMO_MS     = 250;
  localparam int unsigned RESEL_TMO_CYC    = (CLK_HZ / 1000) * RESEL_TMO_MS;
  localparam int unsigned RESEL_TMO_W      = 25;

  // Retry limits
  localparam logic [1:0]  PAR_RETRY_MAX    = 2'h2;
  localparam logic [1:0]  MSG_RETRY_MAX    = 2'h1;
  localparam logic [1:0]  RESEL_RETRY_MAX  = 2'h2;

  // Reset values
  localparam logic [1:0]  CNT_RST          = 2'h0;
  localparam logic [2:0]  ATN_SYNC_RST     = 3'h0;

  // Message that the initiator rejected
  typedef enum logic [2:0] {
    REJ_CMD_CPLT,
    REJ_DISCONNECT,
    REJ_IDENTIFY,
    REJ_LINKED_CPLT,
    REJ_MSG_REJECT,
    REJ_RESTORE_PTR,
    REJ_SAVE_PTR,
    REJ_SYNC_REQ
  } ster_rej_e;

  // Sense key / additional sense recorded for the command
  typedef enum logic [2:0] {
    SNS_NONE,
    SNS_ABORT_PARITY,
    SNS_ABORT_IDE,
    SNS_ABORT_MSG_REJ,
    SNS_ABORT_SEL_FAIL,
    SNS_ABORT_INT_CTL,
    SNS_HW_INT_CTL
  } ster_sense_e;

  // Recovery in progress
  typedef enum logic [2:0] {
    KIND_NONE,
    KIND_MSG_OUT,
    KIND_CMD,
    KIND_DATA_OUT,
    KIND_IDE,
    KIND_MPE
  } ster_kind_e;

  // One-cycle events from the bus phase engine
  typedef struct packed {
    logic mo_par;
    logic cmd_par;
    logic do_par;
    logic ide_msg;
    logic mpe_msg;
    logic rej_msg;
    logic int_err;
    logic hs_tmo;
    logic phase_ok;
    logic no_retry;
    logic resel_go;
    logic resel_ack;
  } ster_evt_s;

  // Levels describing the current nexus
  typedef struct packed {
    logic lun_known;
    logic disc_priv;
    logic retry_status;
  } ster_ctx_s;

  // Orders to the bus phase engine, one-cycle pulses except hold_hs
  typedef struct packed {
    logic hold_hs;
    logic req_resend;
    logic msgin_restore;
    logic resend_msg;
    logic check_cond;
    logic bus_free;
    logic abort_cmd;
    logic link_break;
    logic keep_conn;
    logic resel_abort;
    logic resel_retry;
    logic sense_set;
  } ster_act_s;

endpackage : ster_pkg

/* File: dv/ster_core_props.sv */
// Checker for the recovery sequencer, attached to its ports by bind.
// Assumes events and orders other than hold_hs are one-cycle pulses on MCLK_I.
module ster_core_props #(
  parameter logic [ster_pkg::RESEL_TMO_W-1:0] RESEL_TMO_CYC = 25'h32
) (
  // Clock and reset
  input wire logic                  MCLK_I,
  input wire logic                  SYS_RST_I,
  // Inputs
  input wire logic                  ATN_I,
  input wire ster_pkg::ster_evt_s   EVT_I,
  input wire ster_pkg::ster_rej_e   REJ_KIND_I,
  input wire ster_pkg::ster_ctx_s   CTX_I,
  // Outputs
  input wire ster_pkg::ster_act_s   ACT_O,
  input wire ster_pkg::ster_sense_e SENSE_O,
  input wire logic                  ASYNC_O,
  input wire logic                  DISC_OK_O,
  input wire logic                  RECOVER_O,
  input wire logic                  RESEL_BUSY_O
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TMO = RESEL_TMO_CYC;
  logic        q;
  logic        rj;
  logic        idle;
  logic [31:0] cnt_r;
  logic [2:0]  atn_hi_r;
  assign q = !EVT_I.hs_tmo && !EVT_I.int_err;
  assign rj = EVT_I.rej_msg && q;
  assign idle = q && !EVT_I.rej_msg && !RECOVER_O && !RESEL_BUSY_O;
  // Consecutive cycles out of reset with ATN high, saturating
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I || !ATN_I) begin
      atn_hi_r <= 3'h0;
    end else if (atn_hi_r != 3'h7) begin
      atn_hi_r <= atn_hi_r + 3'h1;
    end
  end
  // Cycles since reselection started or last timed out
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I || EVT_I.resel_go || ACT_O.resel_abort) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);
  a_tmo_free: assert property (EVT_I.hs_tmo |=> ACT_O.bus_free && ACT_O.abort_cmd
    && SENSE_O == ster_pkg::SNS_ABORT_INT_CTL) else $error("timeout left bus held");
  a_int_chk: assert property (EVT_I.int_err && !EVT_I.hs_tmo && CTX_I.lun_known |=>
    ACT_O.check_cond && SENSE_O == ster_pkg::SNS_HW_INT_CTL) else $error("internal error");
  a_cplt_free: assert property (rj && REJ_KIND_I == ster_pkg::REJ_CMD_CPLT |=>
    ACT_O.bus_free && !ACT_O.abort_cmd && !ACT_O.check_cond) else $error("complete reject");
  a_disc_keep: assert property (rj && REJ_KIND_I == ster_pkg::REJ_DISCONNECT |=>
    ACT_O.keep_conn && !ACT_O.bus_free && DISC_OK_O == $past(CTX_I.disc_priv))
    else $error("disconnect reject");
  a_ident_abort: assert property (rj && REJ_KIND_I == ster_pkg::REJ_IDENTIFY |=>
    ACT_O.bus_free && ACT_O.abort_cmd && SENSE_O == ster_pkg::SNS_ABORT_MSG_REJ)
    else $error("identify reject");
  a_link_break: assert property (rj && REJ_KIND_I == ster_pkg::REJ_LINKED_CPLT |=>
    ACT_O.bus_free && ACT_O.link_break && SENSE_O == ster_pkg::SNS_ABORT_MSG_REJ)
    else $error("linked reject");
  a_rej_check: assert property (rj && REJ_KIND_I == ster_pkg::REJ_MSG_REJECT |=>
    ACT_O.check_cond && !ACT_O.bus_free && SENSE_O == ster_pkg::SNS_ABORT_MSG_REJ)
    else $error("reject of reject");
  a_sync_async: assert property (rj && REJ_KIND_I == ster_pkg::REJ_SYNC_REQ |=>
    ASYNC_O && !ACT_O.bus_free) else $error("sync reject");
  a_mpe_resend: assert property (EVT_I.mpe_msg && idle && !EVT_I.mo_par &&
    !EVT_I.cmd_par && !EVT_I.do_par && !EVT_I.ide_msg |=>
    ACT_O.resend_msg && !ACT_O.bus_free) else $error("no message resend");
  a_par_restore: assert property ((EVT_I.cmd_par || EVT_I.do_par) && idle &&
    !EVT_I.mo_par |=>
    ACT_O.msgin_restore && RECOVER_O) else $error("no restore pointers");
  a_drain_hold: assert property (ACT_O.hold_hs && atn_hi_r >= 3'h4 && q &&
    !EVT_I.rej_msg |=> ACT_O.hold_hs && !ACT_O.req_resend)
    else $error("drain ended with ATN high");
  a_resel_win: assert property (ACT_O.resel_abort |->
    cnt_r + 32'h2 >= TMO && cnt_r <= TMO + 32'h3) else $error("reselection timer length");
endmodule : ster_core_props

bind ster_core ster_core_props #(.RESEL_TMO_CYC(RESEL_TMO_CYC)) u_props (
  .MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .ATN_I(ATN_I), .EVT_I(EVT_I),
  .REJ_KIND_I(REJ_KIND_I), .CTX_I(CTX_I), .ACT_O(ACT_O), .SENSE_O(SENSE_O),
  .ASYNC_O(ASYNC_O), .DISC_OK_O(DISC_OK_O), .RECOVER_O(RECOVER_O),
  .RESEL_BUSY_O(RESEL_BUSY_O)
);

/* File: dv/ster_init_model.sv */
// Initiator model: holds ATN while it has message bytes, drops it when drained.
// Assumes hold_i is the target's drain level; lag_i sets how slowly ATN falls.
module ster_init_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Bench control
  input  wire logic       atn_req_i,
  input  wire logic [3:0] lag_i,
  input  wire logic       hold_i,
  // Bus pin
  output logic            atn_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      atn_o <= 1'b0;
      cnt_r <= '0;
    end else if (!hold_i) begin
      // Raised again for a whole resend of the message
      atn_o <= atn_req_i;
      cnt_r <= '0;
    end else if (atn_o && cnt_r == lag_i) begin
      atn_o <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule : ster_init_model

/* File: dv/ster_core_tb.sv */
// Self-checking bench for the bus error recovery sequencer with an initiator model.
// Assumes a short reselection timer so each timeout takes TMO + 1 clock cycles.
module ster_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TMO = 50;
  localparam ster_pkg::ster_act_s SSET = '{sense_set: 1'b1, default: 1'b0};
  logic                  clk;
  logic                  rst;
  logic                  atn_req;
  logic                  atn;
  logic [3:0]            lag;
  logic                  async;
  logic                  disc_ok;
  logic                  recov;
  logic                  rbusy;
  ster_pkg::ster_evt_s   evt;
  ster_pkg::ster_evt_s   e;
  ster_pkg::ster_rej_e   rk;
  ster_pkg::ster_ctx_s   ctx;
  ster_pkg::ster_act_s   act;
  ster_pkg::ster_act_s   xa;
  ster_pkg::ster_sense_e sense;
  ster_pkg::ster_sense_e xs;
  int                    err_total;
  int                    n_tests;
  int                    n;

  ster_core #(.RESEL_TMO_CYC(25'(TMO))) DUT (
    .MCLK_I(clk), .SYS_RST_I(rst), .ATN_I(atn), .EVT_I(evt), .REJ_KIND_I(rk),
    .CTX_I(ctx), .ACT_O(act), .SENSE_O(sense), .ASYNC_O(async), .DISC_OK_O(disc_ok),
    .RECOVER_O(recov), .RESEL_BUSY_O(rbusy)
  );
  ster_init_model u_init (
    .clk_i(clk), .rst_i(rst), .atn_req_i(atn_req), .lag_i(lag), .hold_i(act.hold_hs),
    .atn_o(atn)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic ster_pkg::ster_act_s fail(input logic chk_c);
    fail = '0;
    fail.check_cond = chk_c;
    fail.bus_free = !chk_c;
    fail.abort_cmd = !chk_c;
  endfunction : fail

  function automatic ster_pkg::ster_sense_e par(input logic known);
    return known ? ster_pkg::SNS_ABORT_PARITY : ster_pkg::SNS_NONE;
  endfunction : par

  function automatic void exp_rej(input ster_pkg::ster_rej_e k);
    xa = fail(1'b1);
    xs = ster_pkg::SNS_ABORT_MSG_REJ;
    case (k)
      ster_pkg::REJ_CMD_CPLT: begin
        xa = '{bus_free: 1'b1, default: 1'b0};
        xs = ster_pkg::SNS_NONE;
      end
      ster_pkg::REJ_IDENTIFY, ster_pkg::REJ_LINKED_CPLT: begin
        xa = fail(1'b0);
        xa.link_break = k == ster_pkg::REJ_LINKED_CPLT;
      end
      ster_pkg::REJ_MSG_REJECT: xs = ster_pkg::SNS_ABORT_MSG_REJ;
      ster_pkg::REJ_RESTORE_PTR: xs = ster_pkg::SNS_ABORT_PARITY;
      default: begin
        xa = '{keep_conn: k != ster_pkg::REJ_SYNC_REQ, default: 1'b0};
        xs = ster_pkg::SNS_NONE;
      end
    endcase
  endfunction : exp_rej

  task automatic end_sim;
    $display("Mismatches %0d, comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input bit ok, input string m);
    n_tests++;
    if (!ok) begin
      err_total++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic ca(input ster_pkg::ster_act_s x, input ster_pkg::ster_sense_e s, string m);
    chk((act & ~SSET) === x && sense === s, m);
  endtask : ca

  task automatic ev(input ster_pkg::ster_evt_s v,
                    input ster_pkg::ster_rej_e r = ster_pkg::REJ_CMD_CPLT);
    @(posedge clk);
    evt <= v;
    rk <= r;
    @(posedge clk);
    evt <= '0;
    #1;
  endtask : ev

  task automatic wact(input ster_pkg::ster_act_s m, input int lim);
    n = 0;
    while ((|(act & m)) !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim) begin
        chk(1'b0, "wait ran out");
        end_sim;
      end
    end
  endtask : wact

  task automatic do_rst;
    @(posedge clk);
    rst <= 1'b1;
    atn_req <= 1'b0;
    ctx <= ster_pkg::ster_ctx_s'(3'($urandom_range(7)));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(act === '0 && sense === ster_pkg::SNS_NONE && async === 1'b0 && disc_ok === 1'b1
        && recov === 1'b0 && rbusy === 1'b0, "reset values");
  endtask : do_rst

  initial begin
    rst = 1'b1;
    evt = '0;
    rk = ster_pkg::REJ_CMD_CPLT;
    ctx = '0;
    atn_req = 1'b0;
    lag = 4'h0;
    err_total = 0;
    n_tests = 0;
    void'($urandom(73958));
    // Message Out: two drains and resends, then give up
    do_rst;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      atn_req <= 1'b1;
      lag <= 4'($urandom_range(12));
      repeat (6) @(posedge clk);
      ev('{mo_par: 1'b1, default: 1'b0});
      if (i < 2) begin
        chk(act.hold_hs === 1'b1 && recov === 1'b1, "no drain");
        wact('{req_resend: 1'b1, default: 1'b0}, 40);
        chk(act.hold_hs === 1'b0 && atn === 1'b0, "resend while ATN high");
      end else begin
        ca(fail(ctx.lun_known), par(ctx.lun_known), "message out give up");
      end
    end
    // Command and Data Out parity, third error fails
    for (int k = 0; k < 2; k++) begin
      do_rst;
      for (int i = 0; i < 3; i++) begin
        e = '{cmd_par: k == 0, do_par: k == 1, default: 1'b0};
        ev(e);
        if (i < 2) begin
          ca('{msgin_restore: 1'b1, default: 1'b0}, ster_pkg::SNS_NONE, "no restore");
        end else begin
          ca(fail(ctx.lun_known || k == 1), par(ctx.lun_known || k == 1), "fail");
        end
      end
    end
    // Initiator Detected Error, then repeat or no retry
    do_rst;
    ev('{ide_msg: 1'b1, default: 1'b0});
    ca('{msgin_restore: 1'b1, default: 1'b0}, ster_pkg::SNS_NONE, "ide restore");
    e = '{ide_msg: 1'($urandom_range(1)), default: 1'b0};
    e.no_retry = !e.ide_msg;
    ev(e);
    xs = ctx.retry_status ? ster_pkg::SNS_NONE : ster_pkg::SNS_ABORT_IDE;
    ca(fail(!ctx.retry_status), xs, "ide give up");
    // Message Parity Error twice
    do_rst;
    ev('{mpe_msg: 1'b1, default: 1'b0});
    ca('{resend_msg: 1'b1, default: 1'b0}, ster_pkg::SNS_NONE, "no resend");
    ev('{mpe_msg: 1'b1, default: 1'b0});
    ca(fail(1'b0), ster_pkg::SNS_ABORT_PARITY, "second parity message");
    // Every rejected message kind
    for (int k = 0; k < 8; k++) begin
      do_rst;
      if (k == 5) begin
        ev('{do_par: 1'b1, default: 1'b0});
      end
      ev('{rej_msg: 1'b1, default: 1'b0}, ster_pkg::ster_rej_e'(k));
      exp_rej(ster_pkg::ster_rej_e'(k));
      ca(xa, xs, "reject handling");
      chk(async === (k == 7) && disc_ok === (k != 1 || ctx.disc_priv), "mode levels");
    end
    // Internal error beats a reject; timeout beats an internal error
    do_rst;
    ev('{int_err: 1'b1, rej_msg: 1'b1, default: 1'b0}, ster_pkg::REJ_MSG_REJECT);
    xs = ctx.lun_known ? ster_pkg::SNS_HW_INT_CTL : ster_pkg::SNS_NONE;
    ca(fail(ctx.lun_known), xs, "internal error");
    ev('{cmd_par: 1'b1, default: 1'b0});
    ev('{hs_tmo: 1'b1, int_err: 1'b1, default: 1'b0});
    ca(fail(1'b0), ster_pkg::SNS_ABORT_INT_CTL, "handshake timeout");
    chk(recov === 1'b0, "state kept after abrupt free");
    // Reselection: three timeouts, then an answered one
    do_rst;
    ev('{resel_go: 1'b1, default: 1'b0});
    chk(rbusy === 1'b1, "timer idle");
    for (int i = 0; i < 3; i++) begin
      wact('{resel_abort: 1'b1, default: 1'b0}, TMO + 5);
      chk(n >= TMO - 3 && n <= TMO + 2, "timer length");
      xa = '{resel_abort: 1'b1, resel_retry: i < 2, abort_cmd: i == 2, default: 1'b0};
      ca(xa, i < 2 ? ster_pkg::SNS_NONE : ster_pkg::SNS_ABORT_SEL_FAIL, "resel end");
      @(posedge clk);
      #1;
    end
    ev('{resel_go: 1'b1, default: 1'b0});
    ev('{resel_ack: 1'b1, default: 1'b0});
    chk(rbusy === 1'b0, "timer kept running");
    end_sim;
  end
endmodule : ster_core_tb
